// *** core/flsp_core.sv ***
//Contract
//RULE1: Bit 7 low while busy, high idle
//RULE2: Erase suspend sets ready and erase-suspended
//RULE3: Erase failure and bad sequence flag errors
//RULE4: Failed word program sets bit 4
//RULE5: Supply flag updated only at finish/abort
//RULE6: Program suspend sets ready and program-suspended
//RULE7: Locked target aborts, sets bit 1
//RULE8: Busy bit 0 tells own versus other
//RULE9: Idle reads bit 0 as zero
//RULE10: Streaming mode redefines bit 0
//RULE11: Clear status keeps read modes
//RULE12: Error bits sticky until clear command
//RULE13: Reset pin clears status register
//RULE14: Host clears status after any error
//RULE15: Program only pulls ones to zero
//RULE16: Host programs one partition at once
//RULE17: Each read falling edge refreshes status
//RULE18: Busy partition accepts read-type and suspend
//RULE19: Stay in status read after program
//RULE20: Standby waits for program completion
//RULE21: Setup 40h then data starts program
//RULE22: Supply-low flag refuses further programs
//RULE23: Upper data byte zero in status
//RULE24: Status read default after program/erase
//RULE25: Other commands to busy partition ignored
`timescale 1ns/1ps
`include "flsp_consts.svh"
module flsp_core import flsp_pkg::*; #(
  parameter logic [15:0] ID_CODE = 16'h5A5A // Arbitrary identifier value
) (
  input  wire logic                    clock,      // 25 MHz system clock
  input  wire logic                    sys_rst,    // Synchronous reset, high
  input  wire logic                    rst_n,      // Device reset pin, low
  input  wire logic                    ce_n,       // Chip enable pin, low
  input  wire logic                    oe_n,       // Output enable pin, low
  input  wire logic                    we_n,       // Write enable pin, low
  input  wire logic                    wp_n,       // Write protect pin, low locks
  input  wire logic                    vpp_ok,     // Programming supply in range
  input  wire logic                    cell_fault, // Cells fail to verify
  input  wire logic [`FLSP_ADDR_W-1:0] addr,       // Word address pins
  input  wire logic [15:0]             dq_in,      // Data pins, input side
  output logic      [15:0]             dq_out,     // Data pins, output side
  output logic                         dq_oe,      // Data pins driven
  output logic                         standby,    // Device in standby
  output logic                         engine_ready // Device-wide ready
);
  logic [`FLSP_PIN_W-1:0]   pins_s;
  logic                     s_rst_n, s_ce_n, s_oe_n, s_we_n, s_wp_n, s_vpp, s_fault;
  logic [`FLSP_ADDR_W-1:0]  s_addr;
  logic [15:0]              s_dq;

  flsp_sync #(.W(`FLSP_PIN_W), .INIT(`FLSP_PIN_INIT)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     ({rst_n, ce_n, oe_n, we_n, wp_n, vpp_ok, cell_fault, addr, dq_in}),
    .dout    (pins_s)
  );
  assign {s_rst_n, s_ce_n, s_oe_n, s_we_n, s_wp_n, s_vpp, s_fault, s_addr, s_dq} = pins_s;

  flsp_wsm_t              state_q, state_d;
  flsp_seq_t              seq_q, seq_d;
  flsp_rmode_t            mode_q [`FLSP_NPART];
  flsp_rmode_t            mode_d [`FLSP_NPART];
  logic [15:0]            mem_q  [`FLSP_NWORD];
  logic [15:0]            mem_d  [`FLSP_NWORD];
  logic [`FLSP_NPART-1:0] ess_q, es_q, ps_q, supply_low_flag_q, pss_q, dps_q;
  logic [`FLSP_NPART-1:0] ess_d, es_d, ps_d, supply_low_flag_d, pss_d, dps_d;
  logic [`FLSP_PART_W-1:0] bp_q, bp_d;
  logic [`FLSP_ADDR_W-1:0] tgt_q, tgt_d;
  logic [15:0]            wd_q, wd_d;
  logic [`FLSP_TMR_W-1:0] tmr_q, tmr_d;
  logic                   we_prev_q, rd_prev_q;
  logic [15:0]            dq_out_q, dq_out_d;
  logic                   dq_oe_q, dq_oe_d, standby_q, standby_d, ready_q, ready_d;

  logic                    wr_stb, rd_act, rd_edge, running, busy_here;
  logic [`FLSP_PART_W-1:0] part;
  logic [7:0]              cmd, sr_v;

  assign part    = s_addr[`FLSP_ADDR_W-1 -: `FLSP_PART_W];
  assign cmd     = s_dq[7:0];
  assign wr_stb  = s_we_n & ~we_prev_q & ~s_ce_n;
  assign rd_act  = ~s_ce_n & ~s_oe_n & s_we_n;
  assign rd_edge = rd_act & ~rd_prev_q;
  assign running = (state_q == WS_PROG) || (state_q == WS_ERASE);
  assign busy_here = running && (part == bp_q);

  // Status as seen from the addressed partition
  always_comb begin
    sr_v                 = `FLSP_ZERO8;
    sr_v[`FLSP_SR_READY] = ~running;                    // see RULE1
    sr_v[`FLSP_SR_ESS]   = ess_q[part];
    sr_v[`FLSP_SR_ES]    = es_q[part];
    sr_v[`FLSP_SR_PS]    = ps_q[part];
    sr_v[`FLSP_SR_SUPPLY_LOW_FLAG]  = supply_low_flag_q[part];
    sr_v[`FLSP_SR_PSS]   = pss_q[part];
    sr_v[`FLSP_SR_DPS]   = dps_q[part];
    // No streaming mode here, so bit 0 selects own versus other only while busy, zero when idle or suspended
    sr_v[`FLSP_SR_PWS]   = running && (bp_q != part); // see RULE8 see RULE9 see RULE10
  end

  always_comb begin
    state_d = state_q;
    seq_d   = seq_q;
    mode_d  = mode_q;
    mem_d   = mem_q;
    ess_d   = ess_q;
    es_d    = es_q;
    ps_d    = ps_q;
    supply_low_flag_d  = supply_low_flag_q;
    pss_d   = pss_q;
    dps_d   = dps_q;
    bp_d    = bp_q;
    tgt_d   = tgt_q;
    wd_d    = wd_q;
    tmr_d   = tmr_q;
    if (wr_stb) begin
      if (seq_q == SQ_PROG) begin
        // Second cycle carries the word; it cannot be a command
        seq_d        = SQ_NONE;
        mode_d[part] = RM_STATUS;                        // see RULE19 see RULE24
        bp_d         = part;
        tgt_d        = s_addr;
        wd_d         = s_dq;
        if (supply_low_flag_q[part]) begin
          supply_low_flag_d[part] = 1'b1;                           // see RULE22
        end else if (!s_vpp) begin
          supply_low_flag_d[part] = 1'b1;                           // see RULE5
        end else if (!s_wp_n) begin
          dps_d[part] = 1'b1;                            // see RULE7
        end else begin
          state_d = WS_PROG;                             // see RULE21
          tmr_d   = `FLSP_TMR_W'(`FLSP_PROG_CYC);
        end
      end else if (seq_q == SQ_ERASE) begin
        seq_d        = SQ_NONE;
        mode_d[part] = RM_STATUS;                        // see RULE24
        bp_d         = part;
        tgt_d        = s_addr;
        if (cmd != `FLSP_CMD_CONFIRM) begin
          es_d[part] = 1'b1;                             // see RULE3
          ps_d[part] = 1'b1;
        end else if (supply_low_flag_q[part] || !s_vpp) begin
          supply_low_flag_d[part] = 1'b1;                           // see RULE5
        end else if (!s_wp_n) begin
          dps_d[part] = 1'b1;                            // see RULE7
        end else begin
          state_d = WS_ERASE;
          tmr_d   = `FLSP_TMR_W'(`FLSP_ERASE_CYC);
        end
      end else begin
        unique case (cmd)
          `FLSP_CMD_RSTAT: mode_d[part] = RM_STATUS;     // see RULE18
          `FLSP_CMD_RARR:  mode_d[part] = RM_ARRAY;      // see RULE18
          `FLSP_CMD_RID:   mode_d[part] = RM_ID;         // see RULE18
          `FLSP_CMD_RQRY:  mode_d[part] = RM_QUERY;      // see RULE18
          `FLSP_CMD_CLR: begin
            // Clearing a partition still running would hide its outcome
            if (!busy_here) begin                        // see RULE25
              ess_d[part]  = 1'b0;                       // see RULE11 see RULE12
              es_d[part]   = 1'b0;
              ps_d[part]   = 1'b0;
              supply_low_flag_d[part] = 1'b0;
              pss_d[part]  = 1'b0;
              dps_d[part]  = 1'b0;
            end
          end
          `FLSP_CMD_SUSP: begin
            if (busy_here && state_q == WS_PROG) begin
              state_d   = WS_PSUSP;                      // see RULE6
              pss_d[bp_q] = 1'b1;
            end else if (busy_here && state_q == WS_ERASE) begin
              state_d   = WS_ESUSP;                      // see RULE2
              ess_d[bp_q] = 1'b1;
            end
          end
          `FLSP_CMD_CONFIRM: begin
            if (part == bp_q && state_q == WS_PSUSP) begin
              state_d     = WS_PROG;                     // see RULE6
              pss_d[bp_q] = 1'b0;
            end else if (part == bp_q && state_q == WS_ESUSP) begin
              state_d     = WS_ESUSP == state_q ? WS_ERASE : state_q; // see RULE2
              ess_d[bp_q] = 1'b0;
            end
          end
          `FLSP_CMD_PROG, `FLSP_CMD_PROG2: begin
            if (state_q == WS_IDLE) begin                // see RULE25
              seq_d = SQ_PROG;
            end
          end
          `FLSP_CMD_ERASE: begin
            if (state_q == WS_IDLE) begin
              seq_d = SQ_ERASE;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Internal timing advances only when no command redirected the engine
    if (running && state_d == state_q) begin
      if (tmr_q == `FLSP_TMR_ONE) begin
        state_d = WS_IDLE;                               // see RULE1
        if (!s_vpp) begin
          supply_low_flag_d[bp_q] = 1'b1;                           // see RULE5
        end else if (state_q == WS_PROG) begin
          mem_d[tgt_q] = mem_q[tgt_q] & wd_q;            // see RULE15
          if (s_fault) begin
            ps_d[bp_q] = 1'b1;                           // see RULE4
          end
        end else begin
          for (int i = 0; i < `FLSP_NWORD; i++) begin
            if (i[`FLSP_ADDR_W-1 -: `FLSP_PART_W] == bp_q) begin
              mem_d[i] = `FLSP_ERASED;
            end
          end
          if (s_fault) begin
            es_d[bp_q] = 1'b1;                           // see RULE3
          end
        end
      end else begin
        tmr_d = tmr_q - `FLSP_TMR_ONE;
      end
    end
    if (!s_rst_n) begin
      state_d = WS_IDLE;
      seq_d   = SQ_NONE;
      ess_d   = '0;                                      // see RULE13
      es_d    = '0;
      ps_d    = '0;
      supply_low_flag_d  = '0;
      pss_d   = '0;
      dps_d   = '0;
      for (int p = 0; p < `FLSP_NPART; p++) begin
        mode_d[p] = RM_ARRAY;
      end
    end
  end

  // Read path: data latched on each new read, held for the rest of it
  always_comb begin
    dq_out_d  = dq_out_q;
    dq_oe_d   = rd_act;
    if (rd_edge) begin                                   // see RULE17
      unique case (mode_q[part])
        RM_STATUS: dq_out_d = {`FLSP_ZERO8, sr_v};       // see RULE23
        RM_ARRAY:  dq_out_d = mem_q[s_addr];
        RM_ID:     dq_out_d = ID_CODE;
        RM_QUERY:  dq_out_d = `FLSP_ZERO16;
      endcase
    end
    standby_d = s_ce_n && !running;                      // see RULE20
    ready_d   = ~running;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q   <= WS_IDLE;
      seq_q     <= SQ_NONE;
      ess_q     <= '0;
      es_q      <= '0;
      ps_q      <= '0;
      supply_low_flag_q    <= '0;
      pss_q     <= '0;
      dps_q     <= '0;
      bp_q      <= '0;
      tgt_q     <= '0;
      wd_q      <= `FLSP_ERASED;
      tmr_q     <= '0;
      we_prev_q <= 1'b1;
      rd_prev_q <= 1'b0;
      dq_out_q  <= `FLSP_ZERO16;
      dq_oe_q   <= 1'b0;
      standby_q <= 1'b1;
      ready_q   <= 1'b1;
      for (int i = 0; i < `FLSP_NWORD; i++) begin
        mem_q[i] <= `FLSP_ERASED;
      end
      for (int p = 0; p < `FLSP_NPART; p++) begin
        mode_q[p] <= RM_ARRAY;
      end
    end else begin
      state_q   <= state_d;
      seq_q     <= seq_d;
      ess_q     <= ess_d;
      es_q      <= es_d;
      ps_q      <= ps_d;
      supply_low_flag_q    <= supply_low_flag_d;
      pss_q     <= pss_d;
      dps_q     <= dps_d;
      bp_q      <= bp_d;
      tgt_q     <= tgt_d;
      wd_q      <= wd_d;
      tmr_q     <= tmr_d;
      we_prev_q <= s_we_n;
      rd_prev_q <= rd_act;
      dq_out_q  <= dq_out_d;
      dq_oe_q   <= dq_oe_d;
      standby_q <= standby_d;
      ready_q   <= ready_d;
      mem_q     <= mem_d;
      mode_q    <= mode_d;
    end
  end

  assign dq_out       = dq_out_q;
  assign dq_oe        = dq_oe_q;
  assign standby      = standby_q;
  assign engine_ready = ready_q;
endmodule

// *** core/flsp_consts.svh ***
`ifndef FLSP_CONSTS_SVH
`define FLSP_CONSTS_SVH

`define FLSP_ADDR_W      6
`define FLSP_PART_W      2
`define FLSP_NPART       4
`define FLSP_NWORD       64

`define FLSP_CMD_PROG    8'h40
`define FLSP_CMD_PROG2   8'h10
`define FLSP_CMD_ERASE   8'h20
`define FLSP_CMD_CONFIRM 8'hD0
`define FLSP_CMD_SUSP    8'hB0
`define FLSP_CMD_RSTAT   8'h70
`define FLSP_CMD_CLR     8'h50
`define FLSP_CMD_RARR    8'hFF
`define FLSP_CMD_RID     8'h90
`define FLSP_CMD_RQRY    8'h98

`define FLSP_SR_READY    7
`define FLSP_SR_ESS      6
`define FLSP_SR_ES       5
`define FLSP_SR_PS       4
`define FLSP_SR_SUPPLY_LOW_FLAG     3
`define FLSP_SR_PSS      2
`define FLSP_SR_DPS      1
`define FLSP_SR_PWS      0

`define FLSP_ERASED      16'hFFFF
`define FLSP_ZERO16      16'h0000
`define FLSP_ZERO8       8'h00

`define FLSP_CLK_NS      40
`define FLSP_PROG_NS     10000
`define FLSP_ERASE_NS    80000
`define FLSP_PROG_CYC    (`FLSP_PROG_NS / `FLSP_CLK_NS)
`define FLSP_ERASE_CYC   (`FLSP_ERASE_NS / `FLSP_CLK_NS)
`define FLSP_TMR_W       12
`define FLSP_TMR_ONE     12'h001

// Pin bundle: rst_n, ce_n, oe_n, we_n, wp_n, vpp_ok, cell_fault, addr, dq
`define FLSP_PIN_W       29
`define FLSP_PIN_INIT    29'h1F80_0000

`endif

// *** core/flsp_pkg.sv ***
package flsp_pkg;
  typedef enum logic [2:0] {WS_IDLE, WS_PROG, WS_ERASE, WS_PSUSP, WS_ESUSP} flsp_wsm_t;
  typedef enum logic [1:0] {SQ_NONE, SQ_PROG, SQ_ERASE} flsp_seq_t;
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} flsp_rmode_t;
endpackage

// *** core/flsp_sync.sv ***
`timescale 1ns/1ps
module flsp_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic         clock,   // System clock
  input  wire logic         sys_rst, // Synchronous reset, high
  input  wire logic [W-1:0] din,     // Asynchronous pin levels
  output logic      [W-1:0] dout     // Filtered, synchronous levels
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // A bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// *** sim/flsp_core_sva.sv ***
`timescale 1ns/1ps
module flsp_core_sva (
  input wire logic        clock,       // Clock
  input wire logic        sys_rst,     // Reset
  input wire logic        rst_n,       // Reset pin
  input wire logic        ce_n,        // Chip enable
  input wire logic        oe_n,        // Output enable
  input wire logic        we_n,        // Write strobe
  input wire logic [15:0] dq_out,      // Read data
  input wire logic        dq_oe,       // Data drive
  input wire logic        standby,     // Standby
  input wire logic        engine_ready // Ready
);
  logic        we_q;
  logic        we_d;
  logic [4:0]  age_q;
  logic [4:0]  age_d;
  logic [11:0] busy_q;
  logic [11:0] busy_d;
  // Age of the last write; the engine may only start shortly after one
  always_comb begin
    we_d   = we_n;
    age_d  = (age_q == 5'h1F) ? age_q : age_q + 5'h01;
    busy_d = engine_ready ? 12'h000 : busy_q + 12'h001;
    if (we_n && !we_q) age_d = 5'h00;
    if (sys_rst) age_d = 5'h1F;
    if (sys_rst) busy_d = 12'h000;
  end
  always_ff @(posedge clock) begin
    we_q   <= we_d;
    age_q  <= age_d;
    busy_q <= busy_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst_idle; $fell(sys_rst) |-> engine_ready && standby && !dq_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  property p_pin_rst; !rst_n [*8] |-> engine_ready; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset kept engine");
  property p_busy_bound; busy_q < 12'h834; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("engine busy too long");
  property p_start_write; $fell(engine_ready) |-> age_q < 5'h0C; endproperty
  a_start_write: assert property (p_start_write) else $error("start without write");
  property p_busy_active; !engine_ready [*2] |-> !standby; endproperty
  a_busy_active: assert property (p_busy_active) else $error("standby while busy");
  property p_idle_stby; (ce_n && engine_ready && rst_n) [*8] |-> standby; endproperty
  a_idle_stby: assert property (p_idle_stby) else $error("no standby when idle");
  property p_read_drv; (!ce_n && !oe_n && we_n && rst_n) [*8] |-> dq_oe; endproperty
  a_read_drv: assert property (p_read_drv) else $error("read not driven");
  property p_out_hold; (oe_n && rst_n) [*8] |=> $stable(dq_out) && !dq_oe; endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved unread");
  c_busy: cover property ($fell(engine_ready));
  c_read: cover property ($rose(dq_oe));
  c_pin: cover property (!rst_n [*8]);
endmodule

// *** sim/flsp_host.sv ***
`timescale 1ns/1ps
`include "flsp_consts.svh"
module flsp_host (
  input  wire logic                    clock,  // Clock
  output logic                         ce_n,   // Chip enable
  output logic                         oe_n,   // Output enable
  output logic                         we_n,   // Write strobe
  output logic [`FLSP_ADDR_W-1:0]      addr,   // Word address
  output logic [15:0]                  dq_in,  // Data to device
  input  wire logic [15:0]             dq_out  // Data from device
);
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = '0;
    dq_in = 16'h0000;
  end
  // Pins pass a synchroniser, so every phase is held several clocks
  task automatic bus_write(input logic [5:0] a, input logic [15:0] d);
    @(negedge clock);
    addr = a;
    dq_in = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (6) @(negedge clock);
    we_n = 1'b1;
    repeat (7) @(negedge clock);
    ce_n = 1'b1;
    dq_in = ~d;
  endtask
  task automatic bus_read(input logic [5:0] a, output logic [15:0] d);
    @(negedge clock);
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    repeat (8) @(negedge clock);
    d = dq_out;
    ce_n = 1'b1;
    oe_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask
endmodule

// *** sim/flsp_core_test.sv ***
`timescale 1ns/1ps
`include "flsp_consts.svh"
module flsp_core_test;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        rst_n = 1'b1;
  logic        wp_n = 1'b1;
  logic        vpp_ok = 1'b1;
  logic        cell_fault = 1'b0;
  logic        ce_n, oe_n, we_n, dq_oe, standby, engine_ready;
  logic [5:0]  addr;
  logic [15:0] dq_in, dq_out, rv;
  int          err_count = 0;
  int          samples_checked = 0;
  always #20 clock = ~clock;
  flsp_host host (.clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out));
  flsp_core dut (.clock(clock), .sys_rst(sys_rst), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .wp_n(wp_n), .vpp_ok(vpp_ok), .cell_fault(cell_fault), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .standby(standby),
    .engine_ready(engine_ready));
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmd(input logic [5:0] a, input logic [7:0] c);
    host.bus_write(a, {8'h00, c});
  endtask
  task automatic prog(input logic [5:0] a, input logic [15:0] d);
    cmd(a, `FLSP_CMD_PROG);
    host.bus_write(a, d);
  endtask
  task automatic st(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e,
                    input string s);
    host.bus_read(a, rv);
    check(rv & m, e, s);
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 2200 && engine_ready !== 1'b1; n++) @(negedge clock);
    check({15'h0000, engine_ready}, 16'h0001, "ready");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (8) @(negedge clock);
    cmd(6'h00, `FLSP_CMD_RSTAT);
    st(6'h00, 16'hFFFF, 16'h0080, "reset");
    $display("test reset done");
    cmd(6'h10, `FLSP_CMD_RSTAT);
    prog(6'h01, 16'hA5F0);
    cmd(6'h01, `FLSP_CMD_CLR);
    check({15'h0000, standby}, 16'h0000, "standby busy");
    st(6'h01, 16'hFF81, 16'h0000, "own busy");
    st(6'h10, 16'hFF81, 16'h0001, "other busy");
    wait_ready;
    repeat (8) @(negedge clock);
    check({15'h0000, standby}, 16'h0001, "standby idle");
    st(6'h01, 16'hFFFF, 16'h0080, "done");
    cmd(6'h01, `FLSP_CMD_RARR);
    st(6'h01, 16'hFFFF, 16'hA5F0, "data");
    prog(6'h01, 16'h0FFF);
    wait_ready;
    cmd(6'h01, `FLSP_CMD_RARR);
    st(6'h01, 16'hFFFF, 16'h05F0, "ones kept");
    $display("test program done");
    cell_fault = 1'b1;
    prog(6'h02, 16'h1234);
    wait_ready;
    cell_fault = 1'b0;
    st(6'h02, 16'hFFFF, 16'h0090, "prog fail");
    cmd(6'h02, `FLSP_CMD_CLR);
    st(6'h02, 16'hFFFF, 16'h0080, "cleared");
    wp_n = 1'b0;
    prog(6'h03, 16'h0000);
    wait_ready;
    wp_n = 1'b1;
    st(6'h03, 16'hFFFF, 16'h0082, "locked");
    cmd(6'h03, `FLSP_CMD_CLR);
    vpp_ok = 1'b0;
    prog(6'h04, 16'h0000);
    wait_ready;
    vpp_ok = 1'b1;
    st(6'h04, 16'hFFFF, 16'h0088, "supply");
    prog(6'h04, 16'h0000);
    repeat (300) @(negedge clock);
    st(6'h04, 16'hFFFF, 16'h0088, "sticky");
    cmd(6'h04, `FLSP_CMD_RARR);
    vpp_ok = 1'b0;
    cmd(6'h04, `FLSP_CMD_CLR);
    vpp_ok = 1'b1;
    st(6'h04, 16'hFFFF, 16'hFFFF, "mode kept");
    cmd(6'h04, `FLSP_CMD_RSTAT);
    st(6'h04, 16'hFFFF, 16'h0080, "clear");
    cmd(6'h20, `FLSP_CMD_ERASE);
    cmd(6'h20, `FLSP_CMD_RSTAT);
    st(6'h20, 16'hFFFF, 16'h00B0, "bad seq");
    cmd(6'h20, `FLSP_CMD_CLR);
    $display("test errors done");
    prog(6'h05, 16'h00FF);
    cmd(6'h05, `FLSP_CMD_SUSP);
    st(6'h05, 16'hFFFF, 16'h0084, "prog susp");
    cmd(6'h05, `FLSP_CMD_CONFIRM);
    st(6'h05, 16'hFF81, 16'h0000, "resumed");
    wait_ready;
    st(6'h05, 16'hFFFF, 16'h0080, "prog end");
    cmd(6'h00, `FLSP_CMD_ERASE);
    cmd(6'h00, `FLSP_CMD_CONFIRM);
    cmd(6'h00, `FLSP_CMD_SUSP);
    st(6'h00, 16'hFFFF, 16'h00C0, "erase susp");
    st(6'h10, 16'hFF81, 16'h0080, "idle other");
    cmd(6'h00, `FLSP_CMD_CONFIRM);
    wait_ready;
    st(6'h00, 16'hFFFF, 16'h0080, "erase end");
    cmd(6'h00, `FLSP_CMD_RARR);
    st(6'h01, 16'hFFFF, 16'hFFFF, "erased");
    $display("test suspend done");
    wp_n = 1'b0;
    prog(6'h30, 16'h0000);
    wait_ready;
    wp_n = 1'b1;
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    cmd(6'h30, `FLSP_CMD_RSTAT);
    st(6'h30, 16'hFFFF, 16'h0080, "pin reset");
    $display("test reset pin done");
    print_verdict;
  end
  // Tests need about 4000 clocks; the margin allows slow answers
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    print_verdict;
  end
endmodule
bind flsp_core flsp_core_sva u_sva (.clock(clock), .sys_rst(sys_rst), .rst_n(rst_n),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .standby(standby),
  .engine_ready(engine_ready));
